// >>> pkg/ofe_pkg.sv
// types shared by the front-end control bank
package ofe_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ADDR,
      ST_DATA
   } ofe_spi_state_t;

   typedef logic [23:0] ofe_word_t;
endpackage : ofe_pkg

// >>> pkg/ofe_regs.svh
// register offsets, field positions, reset values and timing figures for the front-end control bank
`ifndef OFE_REGS_SVH
`define OFE_REGS_SVH

`define OFE_ADDR_W 8
`define OFE_DATA_W 24
`define OFE_FRAME_BITS 6'd32
`define OFE_ADDR_BITS 6'd8

`define OFE_ADDR_GAIN 8'h21
`define OFE_ADDR_EMITTER 8'h22
`define OFE_ADDR_POWER 8'h23
`define OFE_ADDR_SPARE_B 8'h24
`define OFE_ADDR_SPARE_C 8'h25
`define OFE_ADDR_SPARE_D 8'h26
`define OFE_ADDR_FACTORY_A 8'h27
`define OFE_ADDR_FACTORY_B 8'h28
`define OFE_ADDR_ALARM 8'h29
`define OFE_ADDR_SAMPLE 8'h2a

// gain register fields
`define OFE_GAIN_MSB 10
`define OFE_GAIN_LSB 8
`define OFE_CAP_MSB 7
`define OFE_CAP_LSB 3
`define OFE_RES_MSB 2
`define OFE_RES_LSB 0
`define OFE_GAIN_MAX_CODE 3'h4
`define OFE_RES_NONE 3'h7

// emitter register fields
`define OFE_RANGE_MSB 17
`define OFE_RANGE_LSB 16
`define OFE_EM1_MSB 15
`define OFE_EM1_LSB 8
`define OFE_EM2_MSB 7
`define OFE_EM2_LSB 0
`define OFE_EMITTER_MASK 24'h03ffff
`define OFE_CURRENT_DIV_SHIFT 8

// power and transmit register fields
`define OFE_BIT_DYN_TX 20
`define OFE_REF_MSB 18
`define OFE_REF_LSB 17
`define OFE_BIT_DYN_CONV_PART 14
`define OFE_BIT_BRIDGE 11
`define OFE_BIT_HIGH_Z 10
`define OFE_BIT_OSC_DIS 9
`define OFE_BIT_LONG_DIAG 8
`define OFE_BIT_DYN_TIA 4
`define OFE_BIT_DYN_CONV_REST 3
`define OFE_BIT_PD_TX 2
`define OFE_BIT_PD_RX 1
`define OFE_BIT_PD_AFE 0
`define OFE_POWER_MASK 24'h164f1f
`define OFE_GAIN_MASK 24'h0007ff

`define OFE_RESET_VALUE 24'h000000

// reference voltages in millivolts
`define OFE_REF_MV_00 10'd250
`define OFE_REF_MV_01 10'd500
`define OFE_REF_MV_10 10'd1000
`define OFE_REF_MV_11 10'd750

// diagnostics durations
`define OFE_DIAG_FAST_MS 8
`define OFE_DIAG_SLOW_MS 16
`define OFE_MCLK_KHZ 40000

`endif

// >>> rtl/ofe_ctrl_regs.sv
// serial-port register bank and control decode of the optical front end
`timescale 1ns/1ps
`include "ofe_regs.svh"
module ofe_ctrl_regs #(
   parameter int DIAG_FAST_CYCLES = `OFE_DIAG_FAST_MS * `OFE_MCLK_KHZ,
   parameter int DIAG_SLOW_CYCLES = `OFE_DIAG_SLOW_MS * `OFE_MCLK_KHZ,
   parameter logic [23:0] FACTORY_A_VALUE = 24'h5a5a5a,
   parameter logic [23:0] FACTORY_B_VALUE = 24'ha5a5a5
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // serial register port
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   input wire logic spi_cs_n,
   input wire logic read_mode,
   output logic spi_miso,
   output logic spi_miso_oe,
   // converter and sequencer
   input wire logic dyn_pd_phase,
   input wire logic conv_ready_in,
   input wire logic sample_valid,
   input wire logic [23:0] sample_data,
   input wire logic diag_start,
   // receive gain decode
   output logic [3:0] stage_two_gain_x2,
   output logic gain_code_legal,
   output logic [4:0] feedback_cap_enable,
   output logic [6:0] feedback_resistor_sel,
   // transmitter
   output logic [15:0] first_emitter_drive_q8,
   output logic [15:0] second_emitter_drive_q8,
   output logic [7:0] full_scale_ma,
   output logic transmitter_off,
   output logic [9:0] tx_reference_mv,
   output logic driver_bridge_select,
   // power and clock
   output logic transmitter_pd,
   output logic receiver_pd,
   output logic diagnostics_pd,
   output logic converter_part_pd,
   output logic converter_rest_pd,
   output logic transimpedance_pd,
   output logic oscillator_enable,
   // status pins
   output logic conv_ready_out,
   output logic conv_ready_oe,
   output logic diagnostics_complete_out,
   output logic diag_complete_oe
);
   ofe_pkg::ofe_spi_state_t state_reg;
   ofe_pkg::ofe_word_t gain_reg;
   ofe_pkg::ofe_word_t emitter_current_control_reg;
   ofe_pkg::ofe_word_t power_and_transmit_control_reg;
   ofe_pkg::ofe_word_t alarm_pin_control_reg;
   ofe_pkg::ofe_word_t second_emitter_sample_reg;
   ofe_pkg::ofe_word_t rd_shift_reg;
   ofe_pkg::ofe_word_t wr_shift_reg;
   ofe_pkg::ofe_word_t read_word;
   logic [7:0] addr_reg;
   logic [5:0] bit_cnt_reg;
   logic [2:0] pins_level;
   logic sclk_prev_reg;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_active;
   logic write_strobe;
   logic [20:0] diag_cnt_reg;
   logic diag_busy_reg;
   logic diag_done_reg;
   logic [2:0] gain_code;
   logic [1:0] range_code;
   logic [7:0] fs_next;

   // full-scale current in mA for a range and reference code
   function automatic logic [7:0] full_scale_of(input logic [1:0] range, input logic [1:0] ref_code);
      logic [7:0] fs;
      fs = 8'h00;
      case (range)
         2'b01: begin
            case (ref_code)
               2'b00: fs = 8'd25;
               2'b01: fs = 8'd50;
               2'b10: fs = 8'd100;
               default: fs = 8'd75;
            endcase
         end
         2'b00, 2'b10: begin
            case (ref_code)
               2'b00: fs = 8'd50;
               2'b01: fs = 8'd100;
               default: fs = 8'h00;
            endcase
         end
         default: fs = 8'h00;
      endcase
      return fs;
   endfunction : full_scale_of

   // nominal drive current in mA, eight fractional bits
   function automatic logic [15:0] drive_of(input logic [7:0] code, input logic [7:0] fs);
      return 16'(code) * 16'(fs);
   endfunction : drive_of

   ofe_sync #(
      .WIDTH(3)
   ) u_pin_sync (
      .mclk(mclk),
      .reset(reset),
      .async_in({~spi_cs_n, spi_sclk, spi_mosi}),
      .level(pins_level)
   );

   // select enters inverted, so the cleared synchroniser reads an idle bus after reset
   assign cs_active = pins_level[2];
   assign sclk_rise = pins_level[1] & ~sclk_prev_reg;
   assign sclk_fall = ~pins_level[1] & sclk_prev_reg;
   assign write_strobe = sclk_rise && cs_active && state_reg == ofe_pkg::ST_DATA
      && bit_cnt_reg == `OFE_FRAME_BITS - 6'd1 && !read_mode;

   always_ff @(posedge mclk) begin
      if (reset) begin
         sclk_prev_reg <= 1'b0;
      end else begin
         sclk_prev_reg <= pins_level[1];
      end
   end

   // frame: eight address bits then 24 data bits, msb first
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_reg <= ofe_pkg::ST_IDLE;
         bit_cnt_reg <= 6'd0;
         addr_reg <= 8'h00;
         wr_shift_reg <= `OFE_RESET_VALUE;
      end else if (!cs_active) begin
         state_reg <= ofe_pkg::ST_IDLE;
         bit_cnt_reg <= 6'd0;
      end else begin
         case (state_reg)
            ofe_pkg::ST_IDLE: begin
               state_reg <= ofe_pkg::ST_ADDR;
               bit_cnt_reg <= 6'd0;
            end
            ofe_pkg::ST_ADDR: begin
               if (sclk_rise) begin
                  addr_reg <= {addr_reg[6:0], pins_level[0]};
                  bit_cnt_reg <= bit_cnt_reg + 6'd1;
                  if (bit_cnt_reg == `OFE_ADDR_BITS - 6'd1) begin
                     state_reg <= ofe_pkg::ST_DATA;
                  end
               end
            end
            ofe_pkg::ST_DATA: begin
               if (sclk_rise && bit_cnt_reg != `OFE_FRAME_BITS) begin
                  wr_shift_reg <= {wr_shift_reg[22:0], pins_level[0]};
                  bit_cnt_reg <= bit_cnt_reg + 6'd1;
               end
            end
            default: state_reg <= ofe_pkg::ST_IDLE;
         endcase
      end
   end

   always_comb begin
      case (addr_reg)
         `OFE_ADDR_GAIN: read_word = gain_reg;
         `OFE_ADDR_EMITTER: read_word = emitter_current_control_reg;
         `OFE_ADDR_POWER: read_word = power_and_transmit_control_reg;
         `OFE_ADDR_FACTORY_A: read_word = FACTORY_A_VALUE;
         `OFE_ADDR_FACTORY_B: read_word = FACTORY_B_VALUE;
         `OFE_ADDR_ALARM: read_word = alarm_pin_control_reg;
         `OFE_ADDR_SAMPLE: read_word = second_emitter_sample_reg;
         default: read_word = `OFE_RESET_VALUE;
      endcase
   end

   // whole word snapshot on the first serial clock fall after the address, so a conversion mid-read cannot tear it
   always_ff @(posedge mclk) begin
      if (reset) begin
         rd_shift_reg <= `OFE_RESET_VALUE;
         spi_miso <= 1'b0;
         spi_miso_oe <= 1'b0;
      end else begin
         spi_miso_oe <= cs_active && read_mode;
         if (sclk_rise && state_reg == ofe_pkg::ST_ADDR && bit_cnt_reg == `OFE_ADDR_BITS - 6'd1) begin
            rd_shift_reg <= 24'h000000;
         end else if (sclk_fall && state_reg == ofe_pkg::ST_DATA && bit_cnt_reg == `OFE_ADDR_BITS) begin
            spi_miso <= read_word[23];
            rd_shift_reg <= {read_word[22:0], 1'b0};
         end else if (sclk_fall && state_reg == ofe_pkg::ST_DATA) begin
            spi_miso <= rd_shift_reg[23];
            rd_shift_reg <= {rd_shift_reg[22:0], 1'b0};
         end
      end
   end

   // must-be-zero bits are dropped on write and read back as zero
   always_ff @(posedge mclk) begin
      if (reset) begin
         gain_reg <= `OFE_RESET_VALUE;
         emitter_current_control_reg <= `OFE_RESET_VALUE;
         power_and_transmit_control_reg <= `OFE_RESET_VALUE;
         alarm_pin_control_reg <= `OFE_RESET_VALUE;
      end else if (write_strobe) begin
         case (addr_reg)
            `OFE_ADDR_GAIN: gain_reg <= {wr_shift_reg[22:0], pins_level[0]} & `OFE_GAIN_MASK;
            `OFE_ADDR_EMITTER: begin
               emitter_current_control_reg <= {wr_shift_reg[22:0], pins_level[0]}
                  & `OFE_EMITTER_MASK;
            end
            `OFE_ADDR_POWER: begin
               power_and_transmit_control_reg <= {wr_shift_reg[22:0], pins_level[0]}
                  & `OFE_POWER_MASK;
            end
            // spare writes are discarded; a host keeping them zero loses nothing
            `OFE_ADDR_ALARM: alarm_pin_control_reg <= {wr_shift_reg[22:0], pins_level[0]};
            default: gain_reg <= gain_reg;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         second_emitter_sample_reg <= `OFE_RESET_VALUE;
      end else if (sample_valid) begin
         second_emitter_sample_reg <= sample_data;
      end
   end

   assign gain_code = gain_reg[`OFE_GAIN_MSB:`OFE_GAIN_LSB];
   assign range_code = emitter_current_control_reg[`OFE_RANGE_MSB:`OFE_RANGE_LSB];
   assign fs_next = full_scale_of(range_code,
      power_and_transmit_control_reg[`OFE_REF_MSB:`OFE_REF_LSB]);

   // receive gain: forbidden codes fall back to unity and flag illegal
   always_ff @(posedge mclk) begin
      if (reset) begin
         stage_two_gain_x2 <= 4'h2;
         gain_code_legal <= 1'b1;
         feedback_cap_enable <= 5'h00;
         feedback_resistor_sel <= 7'h00;
      end else begin
         gain_code_legal <= gain_code <= `OFE_GAIN_MAX_CODE;
         case (gain_code)
            3'h0: stage_two_gain_x2 <= 4'h2;
            3'h1: stage_two_gain_x2 <= 4'h3;
            3'h2: stage_two_gain_x2 <= 4'h4;
            3'h3: stage_two_gain_x2 <= 4'h6;
            3'h4: stage_two_gain_x2 <= 4'h8;
            default: stage_two_gain_x2 <= 4'h2;
         endcase
         feedback_cap_enable <= gain_reg[`OFE_CAP_MSB:`OFE_CAP_LSB];
         if (gain_reg[`OFE_RES_MSB:`OFE_RES_LSB] == `OFE_RES_NONE) begin
            feedback_resistor_sel <= 7'h00;
         end else begin
            feedback_resistor_sel <= 7'(8'h01 << gain_reg[`OFE_RES_MSB:`OFE_RES_LSB]);
         end
      end
   end

   // transmitter drive
   always_ff @(posedge mclk) begin
      if (reset) begin
         full_scale_ma <= 8'h00;
         transmitter_off <= 1'b0;
         first_emitter_drive_q8 <= 16'h0000;
         second_emitter_drive_q8 <= 16'h0000;
         tx_reference_mv <= `OFE_REF_MV_00;
         driver_bridge_select <= 1'b0;
      end else begin
         full_scale_ma <= fs_next;
         transmitter_off <= range_code == 2'b11;
         first_emitter_drive_q8 <= drive_of(
            emitter_current_control_reg[`OFE_EM1_MSB:`OFE_EM1_LSB], fs_next);
         second_emitter_drive_q8 <= drive_of(
            emitter_current_control_reg[`OFE_EM2_MSB:`OFE_EM2_LSB], fs_next);
         case (power_and_transmit_control_reg[`OFE_REF_MSB:`OFE_REF_LSB])
            2'b00: tx_reference_mv <= `OFE_REF_MV_00;
            2'b01: tx_reference_mv <= `OFE_REF_MV_01;
            2'b10: tx_reference_mv <= `OFE_REF_MV_10;
            default: tx_reference_mv <= `OFE_REF_MV_11;
         endcase
         driver_bridge_select <= power_and_transmit_control_reg[`OFE_BIT_BRIDGE];
      end
   end

   // power: whole-front-end bit overrides both halves
   always_ff @(posedge mclk) begin
      if (reset) begin
         transmitter_pd <= 1'b0;
         receiver_pd <= 1'b0;
         diagnostics_pd <= 1'b0;
         converter_part_pd <= 1'b0;
         converter_rest_pd <= 1'b0;
         transimpedance_pd <= 1'b0;
         oscillator_enable <= 1'b1;
      end else begin
         transmitter_pd <= power_and_transmit_control_reg[`OFE_BIT_PD_AFE]
            | power_and_transmit_control_reg[`OFE_BIT_PD_TX]
            | (dyn_pd_phase & power_and_transmit_control_reg[`OFE_BIT_DYN_TX]);
         receiver_pd <= power_and_transmit_control_reg[`OFE_BIT_PD_AFE]
            | power_and_transmit_control_reg[`OFE_BIT_PD_RX];
         diagnostics_pd <= power_and_transmit_control_reg[`OFE_BIT_PD_AFE];
         converter_part_pd <= dyn_pd_phase
            & power_and_transmit_control_reg[`OFE_BIT_DYN_CONV_PART];
         converter_rest_pd <= dyn_pd_phase
            & power_and_transmit_control_reg[`OFE_BIT_DYN_CONV_REST];
         transimpedance_pd <= dyn_pd_phase
            & power_and_transmit_control_reg[`OFE_BIT_DYN_TIA];
         // with the oscillator off the host must feed an external clock
         oscillator_enable <= ~power_and_transmit_control_reg[`OFE_BIT_OSC_DIS];
      end
   end

   // diagnostics timer; length sampled at start, a later change waits for the next run
   always_ff @(posedge mclk) begin
      if (reset) begin
         diag_cnt_reg <= 21'd0;
         diag_busy_reg <= 1'b0;
         diag_done_reg <= 1'b0;
      end else if (diag_start && !power_and_transmit_control_reg[`OFE_BIT_PD_AFE]) begin
         diag_busy_reg <= 1'b1;
         diag_done_reg <= 1'b0;
         if (power_and_transmit_control_reg[`OFE_BIT_LONG_DIAG]) begin
            diag_cnt_reg <= 21'(DIAG_SLOW_CYCLES - 1);
         end else begin
            diag_cnt_reg <= 21'(DIAG_FAST_CYCLES - 1);
         end
      end else if (diag_busy_reg) begin
         if (diag_cnt_reg == 21'd0) begin
            diag_busy_reg <= 1'b0;
            diag_done_reg <= 1'b1;
         end else begin
            diag_cnt_reg <= diag_cnt_reg - 21'd1;
         end
      end
   end

   // status pins
   always_ff @(posedge mclk) begin
      if (reset) begin
         conv_ready_out <= 1'b0;
         conv_ready_oe <= 1'b1;
         diagnostics_complete_out <= 1'b0;
         diag_complete_oe <= 1'b1;
      end else begin
         conv_ready_out <= conv_ready_in;
         diagnostics_complete_out <= diag_done_reg;
         conv_ready_oe <= ~power_and_transmit_control_reg[`OFE_BIT_HIGH_Z];
         diag_complete_oe <= ~power_and_transmit_control_reg[`OFE_BIT_HIGH_Z];
      end
   end
endmodule : ofe_ctrl_regs

// >>> rtl/ofe_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module ofe_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // raw and filtered levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] second_reg;
   logic [WIDTH-1:0] third_reg;

   always_ff @(posedge mclk) begin
      if (reset) begin
         meta_reg <= '0;
         second_reg <= '0;
         third_reg <= '0;
      end else begin
         meta_reg <= async_in;
         second_reg <= meta_reg;
         third_reg <= second_reg;
      end
   end

   // a bit only moves once stages two and three agree
   always_ff @(posedge mclk) begin
      if (reset) begin
         level <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (second_reg[i] == third_reg[i]) begin
               level[i] <= third_reg[i];
            end
         end
      end
   end
endmodule : ofe_sync

// >>> sim/ofe_ctrl_regs_checker.sv
// property checker for the front-end control bank, bound to its top module
`timescale 1ns/1ps
module ofe_ctrl_regs_checker #(
   parameter int DIAG_FAST_CYCLES = 40,
   parameter int DIAG_SLOW_CYCLES = 80
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // watched inputs
   input wire logic dyn_pd_phase,
   input wire logic conv_ready_in,
   input wire logic diag_start,
   // watched outputs
   input wire logic [3:0] stage_two_gain_x2,
   input wire logic gain_code_legal,
   input wire logic [6:0] feedback_resistor_sel,
   input wire logic [7:0] full_scale_ma,
   input wire logic transmitter_off,
   input wire logic [9:0] tx_reference_mv,
   input wire logic transmitter_pd,
   input wire logic receiver_pd,
   input wire logic diagnostics_pd,
   input wire logic converter_part_pd,
   input wire logic converter_rest_pd,
   input wire logic transimpedance_pd,
   input wire logic conv_ready_out,
   input wire logic conv_ready_oe,
   input wire logic diagnostics_complete_out,
   input wire logic diag_complete_oe
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   AST_GAIN_FORBIDDEN: assert property (!gain_code_legal |-> stage_two_gain_x2 == 4'h2)
      else $error("forbidden gain code not at unity");
   AST_GAIN_SET: assert property (stage_two_gain_x2 inside {4'h2, 4'h3, 4'h4, 4'h6, 4'h8})
      else $error("stage two gain outside legal set");
   AST_RES_ONEHOT: assert property ($onehot0(feedback_resistor_sel))
      else $error("resistor select not one-hot");
   AST_TX_OFF: assert property (transmitter_off |-> full_scale_ma == 8'h00)
      else $error("transmitter off with nonzero full scale");
   AST_REF_SET: assert property (tx_reference_mv inside {10'd250, 10'd500, 10'd750, 10'd1000})
      else $error("reference voltage outside legal set");
   AST_DYN_IDLE: assert property (!$past(dyn_pd_phase) && !$past(reset) |->
      !converter_part_pd && !converter_rest_pd && !transimpedance_pd)
      else $error("dynamic power-down outside phase");
   AST_OE_PAIR: assert property (conv_ready_oe == diag_complete_oe)
      else $error("status output enables disagree");
   AST_CONV_READY: assert property (!$past(reset) |-> conv_ready_out == $past(conv_ready_in))
      else $error("ready output not one cycle behind input");
   AST_AFE_ALL: assert property (diagnostics_pd |-> transmitter_pd && receiver_pd)
      else $error("whole power-down left a part running");
   AST_DIAG_CLEAR: assert property (diag_start && !diagnostics_pd |->
      ##2 !diagnostics_complete_out [*8])
      else $error("diagnostics complete not cleared by start");
endmodule : ofe_ctrl_regs_checker

bind ofe_ctrl_regs ofe_ctrl_regs_checker #(.DIAG_FAST_CYCLES(DIAG_FAST_CYCLES),
   .DIAG_SLOW_CYCLES(DIAG_SLOW_CYCLES)) u_checker (.*);

// >>> sim/ofe_host_model.sv
// host serial master model driving the register port
`timescale 1ns/1ps
module ofe_host_model (
   // clock
   input wire logic mclk,
   // serial port
   output logic spi_sclk,
   output logic spi_mosi,
   output logic spi_cs_n,
   output logic read_mode,
   input wire logic spi_miso
);
   initial begin
      spi_sclk = 1'b0;
      spi_mosi = 1'b0;
      spi_cs_n = 1'b1;
      read_mode = 1'b0;
   end

   // half of a 200 ns serial clock period
   task automatic half();
      repeat (4) @(negedge mclk);
   endtask : half

   // fewer than 32 bits aborts the frame
   task automatic xfer(input logic [7:0] a, input logic [23:0] d, input logic rd,
      input int n, output logic [23:0] q);
      logic [31:0] sh;
      sh = {a, d};
      q = 24'h0;
      half();
      read_mode = rd;
      spi_cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         spi_mosi = sh[31 - i];
         half();
         spi_sclk = 1'b1;
         half();
         // sampled late in the high phase, well after the filtered fall
         if (i >= 8) q = {q[22:0], spi_miso};
         spi_sclk = 1'b0;
      end
      half();
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
      half();
      half();
      read_mode = 1'b0;
   endtask : xfer
endmodule : ofe_host_model

// >>> sim/testbench.sv
// self-checking bench for the front-end control bank
`timescale 1ns/1ps
`include "ofe_regs.svh"
module testbench;
   localparam int FAST = 40;
   localparam int SLOW = 80;
   // arbitrary factory contents
   localparam logic [23:0] FA = 24'h3c3c3c;
   localparam logic [23:0] FB = 24'hc3c3c3;
   logic mclk, reset, spi_sclk, spi_mosi, spi_cs_n, read_mode, spi_miso, spi_miso_oe;
   logic dyn_pd_phase, sample_valid, diag_start, gain_code_legal, transmitter_off;
   logic conv_ready_in = 1'b0;
   logic [23:0] sample_data;
   logic [3:0] stage_two_gain_x2;
   logic [4:0] feedback_cap_enable;
   logic [6:0] feedback_resistor_sel;
   logic [15:0] first_emitter_drive_q8, second_emitter_drive_q8;
   logic [7:0] full_scale_ma;
   logic [9:0] tx_reference_mv;
   logic driver_bridge_select, transmitter_pd, receiver_pd, diagnostics_pd, converter_part_pd;
   logic converter_rest_pd, transimpedance_pd, oscillator_enable, conv_ready_out;
   logic conv_ready_oe, diagnostics_complete_out, diag_complete_oe;
   int errors = 0;
   int n_checks = 0;

   ofe_ctrl_regs #(.DIAG_FAST_CYCLES(FAST), .DIAG_SLOW_CYCLES(SLOW), .FACTORY_A_VALUE(FA),
      .FACTORY_B_VALUE(FB)) u_dut (.*);
   ofe_host_model u_host (.*);

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(negedge mclk) conv_ready_in <= reset ? 1'b0 : ~conv_ready_in;

   task automatic results();
      if (errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      logic [23:0] q;
      u_host.xfer(a, d, 1'b0, 32, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [23:0] q);
      u_host.xfer(a, 24'h0, 1'b1, 32, q);
   endtask : rd

   task automatic rdchk(input logic [7:0] a, input logic [23:0] e);
      logic [23:0] q;
      rd(a, q);
      chk(q, e);
   endtask : rdchk

   task automatic t_reset();
      logic [23:0] q;
      chk(stage_two_gain_x2, 24'h2);
      chk(tx_reference_mv, 24'd250);
      chk({oscillator_enable, driver_bridge_select, conv_ready_oe}, 24'h5);
      chk({transmitter_pd, receiver_pd, diagnostics_pd}, 24'h0);
      u_host.xfer(`OFE_ADDR_EMITTER, 24'h0000ab, 1'b0, 20, q);
      rdchk(`OFE_ADDR_EMITTER, 24'h0);
      rdchk(`OFE_ADDR_POWER, 24'h0);
   endtask : t_reset

   task automatic t_gain();
      logic [3:0] gx2 [8] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'h2, 4'h2, 4'h2};
      for (int i = 0; i < 8; i++) begin
         wr(`OFE_ADDR_GAIN, {13'h0, 3'(i), 5'(15 ^ i), 3'(i)});
         chk(stage_two_gain_x2, 24'(gx2[i]));
         chk(gain_code_legal, 24'(i < 5));
         chk(feedback_cap_enable, 24'(15 ^ i));
         chk(feedback_resistor_sel, (i == 7) ? 24'h0 : 24'(1 << i));
      end
   endtask : t_gain

   task automatic t_emit();
      logic [9:0] mv [4] = '{10'd250, 10'd500, 10'd1000, 10'd750};
      logic [7:0] wide [4] = '{8'd25, 8'd50, 8'd100, 8'd75};
      logic [7:0] fs;
      for (int r = 0; r < 4; r++) begin
         for (int v = 0; v < 4; v++) begin
            wr(`OFE_ADDR_POWER, 24'(v) << 17);
            wr(`OFE_ADDR_EMITTER, {6'h3f, 2'(r), 8'h80, 8'hff});
            fs = (v == 0) ? 8'd50 : (v == 1) ? 8'd100 : 8'd0;
            if (r == 1) fs = wide[v];
            if (r == 3) fs = 8'd0;
            chk(tx_reference_mv, 24'(mv[v]));
            chk(full_scale_ma, 24'(fs));
            chk(transmitter_off, 24'(r == 3));
            chk(first_emitter_drive_q8, 24'(fs) * 24'h80);
            chk(second_emitter_drive_q8, 24'(fs) * 24'hff);
         end
      end
      rdchk(`OFE_ADDR_EMITTER, 24'h0380ff);
   endtask : t_emit

   task automatic t_power();
      logic [23:0] pd_d [6] = '{24'h4, 24'h2, 24'h1, 24'h104018, 24'h104018, 24'he00};
      logic [9:0] pd_e [6] = '{10'h20b, 10'h10b, 10'h38b, 10'h00b, 10'h27b, 10'h004};
      for (int i = 0; i < 6; i++) begin
         wr(`OFE_ADDR_POWER, pd_d[i]);
         dyn_pd_phase = (i == 4);
         repeat (3) @(negedge mclk);
         chk({transmitter_pd, receiver_pd, diagnostics_pd, converter_part_pd,
            converter_rest_pd, transimpedance_pd, oscillator_enable, driver_bridge_select,
            conv_ready_oe, diag_complete_oe}, 24'(pd_e[i]));
      end
      dyn_pd_phase = 1'b0;
      wr(`OFE_ADDR_POWER, 24'hffffff);
      rdchk(`OFE_ADDR_POWER, 24'h164f1f);
      wr(`OFE_ADDR_POWER, 24'h0);
   endtask : t_power

   task automatic t_spare();
      for (int a = 'h24; a <= 'h2a; a++) begin
         if (a != 'h29) wr(8'(a), (a <= 'h26) ? 24'h0 : 24'hffffff);
      end
      wr(`OFE_ADDR_ALARM, 24'h0);
      for (int a = 'h24; a <= 'h26; a++) rdchk(8'(a), 24'h0);
      rdchk(`OFE_ADDR_FACTORY_A, FA);
      rdchk(`OFE_ADDR_FACTORY_B, FB);
      rdchk(`OFE_ADDR_ALARM, 24'h0);
      rdchk(`OFE_ADDR_SAMPLE, 24'h0);
   endtask : t_spare

   task automatic smp(input logic [23:0] d);
      sample_data = d;
      sample_valid = 1'b1;
      @(negedge mclk);
      sample_valid = 1'b0;
   endtask : smp

   task automatic t_sample();
      logic [23:0] q;
      smp(24'h123456);
      rdchk(`OFE_ADDR_SAMPLE, 24'h123456);
      fork
         rd(`OFE_ADDR_SAMPLE, q);
         begin
            repeat (120) @(negedge mclk);
            chk(spi_miso_oe, 24'h1);
            smp(24'habcdef);
         end
      join
      chk(q, 24'h123456);
      rdchk(`OFE_ADDR_SAMPLE, 24'habcdef);
   endtask : t_sample

   task automatic t_diag(input logic slow, input int cyc);
      wr(`OFE_ADDR_POWER, 24'(slow) << 8);
      diag_start = 1'b1;
      @(negedge mclk);
      diag_start = 1'b0;
      repeat (cyc) @(negedge mclk);
      chk(diagnostics_complete_out, 24'h0);
      @(negedge mclk);
      chk(diagnostics_complete_out, 24'h1);
   endtask : t_diag

   initial begin
      reset = 1'b1;
      dyn_pd_phase = 1'b0;
      sample_valid = 1'b0;
      sample_data = 24'h0;
      diag_start = 1'b0;
      repeat (5) @(negedge mclk);
      reset = 1'b0;
      repeat (6) @(negedge mclk);
      t_reset();
      t_gain();
      t_emit();
      t_power();
      t_spare();
      t_sample();
      t_diag(1'b0, FAST);
      t_diag(1'b1, SLOW);
      results();
   end

   initial begin
      repeat (80000) @(posedge mclk);
      errors++;
      results();
   end
endmodule : testbench
